// [lsd_top.sv]
// Level switch discrete-input evaluation with AXI4-Lite registers.
// Assumes raw_count arrives on aclk with a one-cycle raw_valid strobe.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Function
// - The switch turns on when the scaled level reaches the rising threshold, default 55 percent.
// - The switch turns off when the level falls to the falling threshold, default 45 percent.
// - The level result is set only after the on delay has elapsed since covering.
// - The level result is cleared only after the off delay has elapsed since uncovering.
// - Both delays accept 0.0 to 100.0 seconds in tenths.
// - A switch change during a running delay cancels it; the next change reloads the timer and starts again.
// - With inversion on the level status is inverted, otherwise passed unchanged.
// - Raw count, raw switch state, valid threshold and hysteresis are readable.
// - Cyclic data is a logical level byte followed by a status byte.
module lsd_top #(
    parameter int TICK_CYC = lsd_pkg::LSD_TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] raw_count,
    input wire logic raw_valid,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic [15:0] cyclic_data,
    output logic level_out
);
    import lsd_pkg::*;

    // ==========================================================
    // Parameter checks
    if (TICK_CYC < 1) begin : g_tick_low
        $error("TICK_CYC must be at least one");
    end
    // The tick counter is 24 bits wide
    if (TICK_CYC > 16_777_216) begin : g_tick_high
        $error("TICK_CYC must fit the 24-bit tick counter");
    end

    typedef enum {LSD_IDLE, LSD_TIMING} lsd_tmr_e;

    logic inv_r;
    logic [15:0] range_lo_r;
    logic [15:0] range_hi_r;
    logic [7:0] thr_rise_r;
    logic [7:0] thr_fall_r;
    logic [10:0] dly_on_r;
    logic [10:0] dly_off_r;
    logic [15:0] raw_r;
    logic raw_sw_r;
    logic level_r;
    lsd_tmr_e tmr_r;
    logic [10:0] tenths_r;
    logic [23:0] tick_cnt_r;
    logic tick;
    logic [7:0] pct;
    logic sw_nxt;

    // ==========================================================
    // Scaling
    function automatic logic [7:0] lsd_scale(input logic [15:0] raw, input logic [15:0] lo,
                                             input logic [15:0] hi);
        logic [16:0] num;
        logic [16:0] den;
        logic [23:0] prod;
        logic [23:0] q;
        num = 17'(raw) - 17'(lo);
        den = 17'(hi) - 17'(lo);
        prod = 24'(num[15:0]) * 24'd100;
        q = 24'h0;
        // An empty or inverted range reads as 0 percent
        if (raw <= lo || hi <= lo) begin
            q = 24'h0;
        end else if (raw >= hi) begin
            q = 24'd100;
        end else begin
            q = prod / 24'(den[15:0]);
        end
        return q[7:0];
    endfunction

    // Division is combinational; fine at 10 MHz, a trade of area for latency.
    always_comb begin
        pct = lsd_scale(raw_r, range_lo_r, range_hi_r);
        sw_nxt = raw_sw_r;
        if (pct >= thr_rise_r) begin
            sw_nxt = 1'b1;
        end else if (pct <= thr_fall_r) begin
            sw_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_r <= 16'h0;
            raw_sw_r <= 1'b0;
        end else begin
            if (raw_valid) begin
                raw_r <= raw_count;
            end
            raw_sw_r <= sw_nxt;
        end
    end

    // ==========================================================
    // Delay timers
    // Counter idles at zero so every delay starts on a whole tick
    assign tick = (tick_cnt_r == 24'(TICK_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || tmr_r == LSD_IDLE || tick) begin
            tick_cnt_r <= 24'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 24'h1;
        end
    end

    // A return to the old state cancels the run; the next change reloads the full delay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmr_r <= LSD_IDLE;
            tenths_r <= 11'h0;
            level_r <= 1'b0;
        end else begin
            case (tmr_r)
                LSD_IDLE: begin
                    if (raw_sw_r != level_r) begin
                        tenths_r <= raw_sw_r ? dly_on_r : dly_off_r;
                        tmr_r <= LSD_TIMING;
                    end
                end
                LSD_TIMING: begin
                    if (raw_sw_r == level_r) begin
                        tmr_r <= LSD_IDLE;
                    end else if (tenths_r == 11'h0) begin
                        level_r <= raw_sw_r;
                        tmr_r <= LSD_IDLE;
                    end else if (tick) begin
                        tenths_r <= tenths_r - 11'h1;
                    end
                end
                default: tmr_r <= LSD_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Cyclic outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_out <= 1'b0;
            cyclic_data <= 16'h0;
        end else begin
            level_out <= level_r ^ inv_r;
            cyclic_data <= {7'h0, level_r ^ inv_r, LSD_STAT_GOOD};
        end
    end

    // ==========================================================
    // AXI4-Lite write
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_r;
    logic [31:0] wd_r;
    logic [3:0] ws_r;
    logic [31:0] wm;
    logic wr_fire;
    logic wr_ok;

    assign wr_fire = aw_hold_r && w_hold_r && !bvalid;
    assign wm = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
    assign wr_ok = (aw_r <= LSD_DLY_OFF_OFS) && (aw_r[1:0] == 2'b00);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            aw_r <= 8'h0;
            wd_r <= 32'h0;
            ws_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= LSD_RESP_OK;
        end else begin
            awready <= !aw_hold_r && !awready && awvalid;
            wready <= !w_hold_r && !wready && wvalid;
            if (awvalid && awready) begin
                aw_hold_r <= 1'b1;
                aw_r <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'b1;
                wd_r <= wdata;
                ws_r <= wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? LSD_RESP_OK : LSD_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Beyond 100.0 s a setting saturates; the whole word is compared so it never wraps
    function automatic logic [10:0] lsd_sat_dly(input logic [31:0] d);
        return (d > 32'(LSD_DLY_MAX)) ? LSD_DLY_MAX : d[10:0];
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inv_r <= 1'b0;
            range_lo_r <= LSD_RANGE_LO_RST;
            range_hi_r <= LSD_RANGE_HI_RST;
            thr_rise_r <= LSD_THR_RISE_RST;
            thr_fall_r <= LSD_THR_FALL_RST;
            dly_on_r <= LSD_DLY_RST;
            dly_off_r <= LSD_DLY_RST;
        end else if (wr_fire) begin
            case (aw_r)
                LSD_CTRL_OFS: if (ws_r[0]) inv_r <= wd_r[LSD_CTRL_INV_BIT];
                LSD_RANGE_LO_OFS: range_lo_r <= (range_lo_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                LSD_RANGE_HI_OFS: range_hi_r <= (range_hi_r & ~wm[15:0]) | (wd_r[15:0] & wm[15:0]);
                LSD_THR_RISE_OFS: if (ws_r[0]) thr_rise_r <= wd_r[7:0];
                LSD_THR_FALL_OFS: if (ws_r[0]) thr_fall_r <= wd_r[7:0];
                LSD_DLY_ON_OFS: if (ws_r[0]) dly_on_r <= lsd_sat_dly(wd_r);
                LSD_DLY_OFF_OFS: if (ws_r[0]) dly_off_r <= lsd_sat_dly(wd_r);
                default: inv_r <= inv_r;
            endcase
        end
    end

    // ==========================================================
    // AXI4-Lite read
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [7:0] hyst;

    assign hyst = thr_rise_r - thr_fall_r;

    // Data is captured at the address handshake and held until taken

    always_comb begin
        rd_ok = 1'b1;
        rd_mux = 32'h0;
        case (araddr)
            LSD_CTRL_OFS: rd_mux = {31'h0, inv_r};
            LSD_RANGE_LO_OFS: rd_mux = {16'h0, range_lo_r};
            LSD_RANGE_HI_OFS: rd_mux = {16'h0, range_hi_r};
            LSD_THR_RISE_OFS: rd_mux = {24'h0, thr_rise_r};
            LSD_THR_FALL_OFS: rd_mux = {24'h0, thr_fall_r};
            LSD_DLY_ON_OFS: rd_mux = {21'h0, dly_on_r};
            LSD_DLY_OFF_OFS: rd_mux = {21'h0, dly_off_r};
            LSD_RAW_OFS: rd_mux = {16'h0, raw_r};
            LSD_STATUS_OFS: begin
                rd_mux[LSD_ST_RAW_SW_BIT] = raw_sw_r;
                rd_mux[LSD_ST_LEVEL_BIT] = level_r;
                rd_mux[LSD_ST_TIMING_BIT] = (tmr_r == LSD_TIMING);
                rd_mux[LSD_ST_THR_LSB +: 8] = raw_sw_r ? thr_fall_r : thr_rise_r;
                rd_mux[LSD_ST_HYST_LSB +: 8] = hyst;
            end
            LSD_LEVEL_OFS: rd_mux = {24'h0, 7'h0, level_r ^ inv_r};
            LSD_STAT_BYTE_OFS: rd_mux = {24'h0, LSD_STAT_GOOD};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= LSD_RESP_OK;
        end else begin
            arready <= !arready && !rvalid && arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_ok ? LSD_RESP_OK : LSD_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// [lsd_pkg.sv]
// Package for the level switch discrete-input block: register map, reset values, timing.
// Assumes a 10 MHz aclk and 32-bit AXI4-Lite register access.
package lsd_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] LSD_CTRL_OFS = 8'h00;
    localparam logic [7:0] LSD_RANGE_LO_OFS = 8'h04;
    localparam logic [7:0] LSD_RANGE_HI_OFS = 8'h08;
    localparam logic [7:0] LSD_THR_RISE_OFS = 8'h0c;
    localparam logic [7:0] LSD_THR_FALL_OFS = 8'h10;
    localparam logic [7:0] LSD_DLY_ON_OFS = 8'h14;
    localparam logic [7:0] LSD_DLY_OFF_OFS = 8'h18;
    localparam logic [7:0] LSD_RAW_OFS = 8'h1c;
    localparam logic [7:0] LSD_STATUS_OFS = 8'h20;
    localparam logic [7:0] LSD_LEVEL_OFS = 8'h24;
    localparam logic [7:0] LSD_STAT_BYTE_OFS = 8'h28;
    // ==========================================================
    // Field positions
    localparam int LSD_CTRL_INV_BIT = 0;
    localparam int LSD_ST_RAW_SW_BIT = 0;
    localparam int LSD_ST_LEVEL_BIT = 1;
    localparam int LSD_ST_TIMING_BIT = 2;
    localparam int LSD_ST_THR_LSB = 8;
    localparam int LSD_ST_HYST_LSB = 16;
    // ==========================================================
    // Reset values and constants (percent, raw counts, tenths of a second)
    localparam logic [7:0] LSD_THR_RISE_RST = 8'h37;
    localparam logic [7:0] LSD_THR_FALL_RST = 8'h2d;
    localparam logic [15:0] LSD_RANGE_LO_RST = 16'h0000;
    localparam logic [15:0] LSD_RANGE_HI_RST = 16'hffff;
    localparam logic [10:0] LSD_DLY_RST = 11'h000;
    localparam logic [10:0] LSD_DLY_MAX = 11'h3e8;
    localparam logic [7:0] LSD_STAT_GOOD = 8'h80;
    // ==========================================================
    // Timing
    localparam int LSD_CLK_HZ = 10_000_000;
    localparam int LSD_TICK_MS = 100;
    localparam int LSD_TICK_CYC = LSD_CLK_HZ / 1000 * LSD_TICK_MS;
    // ==========================================================
    // Response codes
    localparam logic [1:0] LSD_RESP_OK = 2'b00;
    localparam logic [1:0] LSD_RESP_SLVERR = 2'b10;
endpackage

// [lsd_top_asserts.sv]
// Port-level checks for the level switch block.
// Assumes one aclk domain with synchronous active-low aresetn.
`timescale 1ns/10ps
module lsd_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [15:0] cyclic_data,
    input wire logic level_out
);
    import lsd_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Bus handshakes
    a_bvalid_held: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    a_ready_pulse: assert property (awready |=> !awready) else $error("awready longer than one");
    a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
    a_write_answer: assert property (awready |-> ##[1:3] bvalid) else $error("no write answer");
    a_resp_code: assert property (bvalid |-> bresp == LSD_RESP_OK || bresp == LSD_RESP_SLVERR)
        else $error("bad write response");
    // ==========================================================
    // Cyclic data and coverage
    a_level_byte: assert property (cyclic_data[15:8] == {7'h00, level_out})
        else $error("level byte differs from level");
    a_status_byte: assert property (aresetn [*4] |-> cyclic_data[7:0] == LSD_STAT_GOOD)
        else $error("status byte wrong");
    c_write_err: cover property (bvalid && bresp == LSD_RESP_SLVERR);
    c_level_on: cover property ($rose(level_out));
    c_level_off: cover property ($fell(level_out));
endmodule
bind lsd_top lsd_checker u_chk (.aclk(aclk), .aresetn(aresetn), .awready(awready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rvalid(rvalid), .rready(rready), .cyclic_data(cyclic_data),
    .level_out(level_out));

// [lsd_sensor.sv]
// Capacitance front end model: one count strobe every fourth cycle.
// Assumes the bench sets the count it should report.
`timescale 1ns/10ps
module lsd_sensor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] level_cnt,
    output logic [15:0] raw_count,
    output logic raw_valid
);
    logic [1:0] phase_r;
    // Count toggles off-strobe so sampling without the strobe shows up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 2'h0;
            raw_valid <= 1'b0;
            raw_count <= 16'h0000;
        end else begin
            phase_r <= phase_r + 2'h1;
            raw_valid <= (phase_r == 2'h3);
            raw_count <= (phase_r == 2'h3) ? level_cnt : ~raw_count;
        end
    end
endmodule

// [tb.sv]
// Register-level bench for the level switch block.
// Assumes the block answers AXI4-Lite with registered ready pulses.
`timescale 1ns/10ps
module tb;
    import lsd_pkg::*;
    localparam logic [15:0] CNT_TAB [4] = '{16'd1965, 16'd1850, 16'd1735, 16'd1850};
    localparam logic LVL_TAB [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic aclk, aresetn, raw_valid, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, level_out;
    logic [15:0] raw_count, cnt, cyclic_data;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int n_mismatch = 0;
    int checked = 0;
    lsd_top #(.TICK_CYC(4)) DUT (.aclk(aclk), .aresetn(aresetn), .raw_count(raw_count),
        .raw_valid(raw_valid), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cyclic_data(cyclic_data), .level_out(level_out));
    lsd_sensor u_sensor (.aclk(aclk), .aresetn(aresetn), .level_cnt(cnt),
        .raw_count(raw_count), .raw_valid(raw_valid));
    // ==========================================================
    // Reporting
    task automatic complete_run;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        chk(32'h0, 32'h1);
        complete_run();
    endtask
    // ==========================================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (bvalid !== 1'b1) hang();
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (rvalid !== 1'b1) hang();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rdr(a, rd, rsp);
        chk(rd, e);
        chk({30'h0, rsp}, {30'h0, LSD_RESP_OK});
    endtask
    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, rsp);
        chk({30'h0, rsp}, {30'h0, LSD_RESP_OK});
    endtask
    task automatic lvl(input logic e, input int n);
        for (int i = 0; i < n && level_out !== e; i++) @(posedge aclk);
        chk({31'h0, level_out}, {31'h0, e});
    endtask
    // ==========================================================
    // Sequence
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        cnt = 16'h0000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(LSD_THR_RISE_OFS, {24'h0, LSD_THR_RISE_RST});
        rchk(LSD_THR_FALL_OFS, {24'h0, LSD_THR_FALL_RST});
        rchk(LSD_STAT_BYTE_OFS, {24'h0, LSD_STAT_GOOD});
        rdr(8'h40, rd, rsp);
        chk({30'h0, rsp}, {30'h0, LSD_RESP_SLVERR});
        wr(LSD_RAW_OFS, 32'h1, rsp);
        chk({30'h0, rsp}, {30'h0, LSD_RESP_SLVERR});
        wok(LSD_DLY_ON_OFS, 32'd2000);
        rchk(LSD_DLY_ON_OFS, 32'd1000);
        wok(LSD_DLY_ON_OFS, 32'd0);
        wok(LSD_RANGE_LO_OFS, 32'd1000 - 32'd300);
        wok(LSD_RANGE_HI_OFS, 32'd2000 + 32'd1000);
        // Exact 55 percent point, the band, the exact 45 percent point, then the band again
        for (int k = 0; k < 4; k++) begin
            cnt <= CNT_TAB[k];
            repeat (12) @(posedge aclk);
            chk({31'h0, level_out}, {31'h0, LVL_TAB[k]});
        end
        cnt <= 16'd2900;
        lvl(1'b1, 20);
        rchk(LSD_RAW_OFS, 32'd2900);
        rchk(LSD_STATUS_OFS, 32'h000a2d03);
        chk({16'h0, cyclic_data}, 32'h00000180);
        rchk(LSD_LEVEL_OFS, 32'h1);
        wok(LSD_CTRL_OFS, 32'h1);
        lvl(1'b0, 8);
        rchk(LSD_LEVEL_OFS, 32'h0);
        chk({16'h0, cyclic_data}, 32'h00000080);
        wok(LSD_CTRL_OFS, 32'h0);
        wok(LSD_DLY_ON_OFS, 32'd3);
        wok(LSD_DLY_OFF_OFS, 32'd5);
        lvl(1'b1, 8);
        cnt <= 16'd900;
        repeat (12) @(posedge aclk);
        chk({31'h0, level_out}, 32'h1);
        // Bounce back in mid-delay; the off delay must start over
        cnt <= 16'd2900;
        repeat (8) @(posedge aclk);
        cnt <= 16'd900;
        repeat (16) @(posedge aclk);
        chk({31'h0, level_out}, 32'h1);
        lvl(1'b0, 40);
        cnt <= 16'd2900;
        repeat (12) @(posedge aclk);
        chk({31'h0, level_out}, 32'h0);
        lvl(1'b1, 40);
        // Second variant: observed counts go in unchanged, with a wider band
        wok(LSD_THR_RISE_OFS, 32'd60);
        rdr(LSD_RAW_OFS, rd, rsp);
        wok(LSD_RANGE_LO_OFS, 32'd900);
        wok(LSD_RANGE_HI_OFS, rd);
        rchk(LSD_RANGE_HI_OFS, 32'd2900);
        cnt <= 16'd1800;
        lvl(1'b0, 40);
        rchk(LSD_STATUS_OFS, 32'h000f3c00);
        cnt <= 16'd2000;
        repeat (24) @(posedge aclk);
        chk({31'h0, level_out}, 32'h0);
        cnt <= 16'd2100;
        lvl(1'b1, 40);
        complete_run();
    end
endmodule
